/* File: shared/cesm_pkg.sv */
// constants for the codec event status and mask unit
// assumes byte-wide registers reached at 16-bit addresses on the control port
package cesm_pkg;

  // number of status/mask register pairs
  localparam int N_SRC = 12;

  // status/mask pair indices
  localparam logic [3:0] IDX_ADC_OVF = 4'h0;
  localparam logic [3:0] IDX_MIXER = 4'h1;
  localparam logic [3:0] IDX_RATE_CONV = 4'h2;
  localparam logic [3:0] IDX_PORT_RX = 4'h3;
  localparam logic [3:0] IDX_PORT_TX = 4'h4;
  localparam logic [3:0] IDX_CODEC = 4'h5;
  localparam logic [3:0] IDX_DET_ONE = 4'h6;
  localparam logic [3:0] IDX_DET_TWO = 4'h7;
  localparam logic [3:0] IDX_PART_LOCK = 4'h8;
  localparam logic [3:0] IDX_SUPPLY = 4'h9;
  localparam logic [3:0] IDX_PLL = 4'ha;
  localparam logic [3:0] IDX_PLUG = 4'hb;

  // status register addresses, by index
  localparam logic [15:0] STAT_ADDR [N_SRC] = '{
    16'h1301, 16'h1302, 16'h1303, 16'h1304, 16'h1305, 16'h1308,
    16'h1309, 16'h130a, 16'h130b, 16'h130d, 16'h130e, 16'h130f};

  // mask register addresses, by index
  localparam logic [15:0] MASK_ADDR [N_SRC] = '{
    16'h1316, 16'h1317, 16'h1318, 16'h1319, 16'h131a, 16'h131b,
    16'h1b79, 16'h1b7a, 16'h131c, 16'h131e, 16'h131f, 16'h1320};

  // mask values after reset
  localparam logic [7:0] MASK_RST [N_SRC] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03,
    8'hff, 8'hff, 8'h7f, 8'h01, 8'h01, 8'hff};

  // implemented bits; the rest read as zero
  // every implemented status bit has a mask bit that can silence it
  localparam logic [7:0] STAT_VALID [N_SRC] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03,
    8'hff, 8'hff, 8'h7f, 8'h01, 8'h01, 8'hff};
  localparam logic [7:0] MASK_VALID [N_SRC] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03,
    8'hff, 8'hff, 8'h7f, 8'h01, 8'h01, 8'hff};

  // named mask bit positions
  localparam int SUPPLY_TRIP_BIT = 0;
  localparam int PLL_LOCK_MASK_BIT = 0;
  localparam int POWERDOWN_DONE_MASK_BIT = 0;
  localparam int HEADSET_AUTODETECT_DONE_MASK_BIT = 1;
  localparam int DAC_RATE_UNLOCK_MASK_BIT = 6;
  localparam int ADC_RATE_UNLOCK_MASK_BIT = 5;
  localparam int DAC_RATE_LOCK_MASK_BIT = 3;
  localparam int ADC_RATE_LOCK_MASK_BIT = 0;

  // supply monitor trip threshold in millivolts, analog side
  localparam int SUPPLY_TRIP_THRESHOLD_MV = 2600;

  // wake and miscellaneous detect control
  localparam logic [15:0] ADDR_WAKE_CTRL = 16'h1b71;
  localparam logic [15:0] ADDR_MISC_DET = 16'h1b74;
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [7:0] MISC_RST = 8'h00;
  localparam int WAKE_CLEAR_BIT = 0;
  localparam int VIEW_SEL_BIT = 1;
  localparam logic [7:0] WAKE_LATCHED_BITS = 8'hfc;
  localparam logic [7:0] MISC_LATCHED_BITS = 8'hff;

  // detect flags gated by tip sense power and short detect enable
  localparam logic [7:0] TIP_SENSE_BITS = 8'hc0;
  localparam logic [7:0] SHORT_DET_BITS = 8'h03;

endpackage

/* File: design/cesm_event_unit.sv */
// event status, sticky detect flags, masks and interrupt output of the codec
// assumes a same-clock register port and same-clock event pulses; only the
// supply monitor comparator arrives asynchronously and is synchronised here
`timescale 1ns/1ps
`default_nettype none

module cesm_event_unit (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // event pulses from the sources
  input wire logic [7:0] evt_adc_overflow,
  input wire logic [7:0] evt_mixer,
  input wire logic [7:0] evt_rate_conv,
  input wire logic [7:0] evt_port_receive,
  input wire logic [7:0] evt_port_transmit,
  input wire logic [7:0] evt_codec,
  input wire logic [7:0] evt_detect_one,
  input wire logic [7:0] evt_detect_two,
  input wire logic [7:0] evt_partial_lock,
  input wire logic [7:0] evt_pll_lock,
  input wire logic [7:0] evt_plug,
  // supply monitor comparator, asynchronous
  input wire logic supply_below_threshold,
  // detect circuit conditions
  input wire logic tip_sense_powered,
  input wire logic short_detect_enabled,
  input wire logic detect_mode_active,
  input wire logic standby_latch_enable,
  // outputs
  output logic event_irq,
  output logic [7:0] wake_ctrl_out,
  output logic [7:0] misc_detect_ctrl_out
);
  import cesm_pkg::*;

  // address lookup in a table of offsets
  // bit 4 flags a hit, bits 3:0 give the matching index
  function automatic logic [4:0] addr_lookup(input logic [15:0] a,
                                             input logic [15:0] tbl [N_SRC]);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < N_SRC; i++) begin
      if (a == tbl[i]) begin
        res = {1'b1, i[3:0]};
      end
    end
    return res;
  endfunction

  logic [7:0] stat_r [N_SRC];
  logic [7:0] mask_r [N_SRC];
  logic [7:0] sticky_one_r;
  logic [7:0] sticky_two_r;
  logic [7:0] wake_r;
  logic [7:0] misc_r;
  logic [7:0] evt [N_SRC];
  logic sup_q1_r;
  logic sup_q2_r;
  logic mode_d_r;
  logic [4:0] st_hit;
  logic [4:0] mk_hit;
  logic view_sel;
  logic wake_clear;
  logic mode_restart;
  logic stat_rd;
  logic sticky_rd_one;
  logic sticky_rd_two;
  logic [7:0] rdata_nxt;
  logic irq_nxt;

  // decode of the current access
  assign st_hit = addr_lookup(reg_addr, STAT_ADDR);
  assign mk_hit = addr_lookup(reg_addr, MASK_ADDR);
  assign view_sel = wake_r[VIEW_SEL_BIT];
  assign wake_clear = reg_wr_en && (reg_addr == ADDR_WAKE_CTRL)
                      && reg_wdata[WAKE_CLEAR_BIT];
  assign mode_restart = detect_mode_active && !mode_d_r;
  assign sticky_rd_one = reg_rd_en && st_hit[4] && view_sel && (st_hit[3:0] == IDX_DET_ONE);
  assign sticky_rd_two = reg_rd_en && st_hit[4] && view_sel && (st_hit[3:0] == IDX_DET_TWO);
  assign stat_rd = reg_rd_en && st_hit[4] && !sticky_rd_one && !sticky_rd_two;

  // two-flop synchroniser for the supply comparator
  // only the second stage feeds logic; the first may be metastable
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sup_q1_r <= 1'b0;
      sup_q2_r <= 1'b0;
    end else begin
      sup_q1_r <= supply_below_threshold;
      sup_q2_r <= sup_q1_r;
    end
  end

  // previous detect mode level, for restart detection; resets high so that
  // a mode already active when reset lifts is not taken for a fresh start
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mode_d_r <= 1'b1;
    end else begin
      mode_d_r <= detect_mode_active;
    end
  end

  // event vectors by index, with power and enable gating
  always_comb begin
    evt[IDX_ADC_OVF] = evt_adc_overflow;
    evt[IDX_MIXER] = evt_mixer;
    evt[IDX_RATE_CONV] = evt_rate_conv;
    evt[IDX_PORT_RX] = evt_port_receive;
    evt[IDX_PORT_TX] = evt_port_transmit;
    evt[IDX_CODEC] = evt_codec;
    evt[IDX_DET_ONE] = evt_detect_one & ~(tip_sense_powered ? 8'h00 : TIP_SENSE_BITS);
    evt[IDX_DET_TWO] = evt_detect_two & ~(short_detect_enabled ? 8'h00 : SHORT_DET_BITS);
    evt[IDX_PART_LOCK] = evt_partial_lock;
    evt[IDX_SUPPLY] = {7'h00, sup_q2_r};
    evt[IDX_PLL] = evt_pll_lock;
    evt[IDX_PLUG] = evt_plug;
  end

  // latched status flags: set on event, cleared by a read, set wins
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < N_SRC; i++) begin
        stat_r[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < N_SRC; i++) begin
        if (stat_rd && (st_hit[3:0] == i[3:0])) begin
          stat_r[i] <= evt[i] & STAT_VALID[i];
        end else begin
          stat_r[i] <= (stat_r[i] | evt[i]) & STAT_VALID[i];
        end
      end
      // gated flags drop while their circuit is off; a read in the same
      // cycle must still clear the ungated bits of that register
      if (!tip_sense_powered) begin
        stat_r[IDX_DET_ONE] <= (((stat_rd && (st_hit[3:0] == IDX_DET_ONE))
                                 ? 8'h00 : stat_r[IDX_DET_ONE])
                                | evt[IDX_DET_ONE]) & ~TIP_SENSE_BITS;
      end
      if (!short_detect_enabled) begin
        stat_r[IDX_DET_TWO] <= (((stat_rd && (st_hit[3:0] == IDX_DET_TWO))
                                 ? 8'h00 : stat_r[IDX_DET_TWO])
                                | evt[IDX_DET_TWO]) & ~SHORT_DET_BITS;
      end
    end
  end

  // sticky detect flags: raw events, including those seen in standby
  // a read with view select set empties only the sticky copy
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sticky_one_r <= 8'h00;
      sticky_two_r <= 8'h00;
    end else if (wake_clear || mode_restart) begin
      sticky_one_r <= evt_detect_one;
      sticky_two_r <= evt_detect_two;
    end else begin
      sticky_one_r <= (sticky_rd_one ? 8'h00 : sticky_one_r) | evt_detect_one;
      sticky_two_r <= (sticky_rd_two ? 8'h00 : sticky_two_r) | evt_detect_two;
    end
  end

  // mask registers
  // reserved bits are cut on write so they read back as zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < N_SRC; i++) begin
        mask_r[i] <= MASK_RST[i];
      end
    end else if (reg_wr_en && mk_hit[4]) begin
      mask_r[mk_hit[3:0]] <= reg_wdata & MASK_VALID[mk_hit[3:0]];
    end
  end

  // wake control: latched bits take writes only under standby latch enable
  // bit 0 is a clear strobe and is never stored
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wake_r <= WAKE_RST;
    end else if (reg_wr_en && (reg_addr == ADDR_WAKE_CTRL)) begin
      wake_r <= (standby_latch_enable ? (reg_wdata & WAKE_LATCHED_BITS)
                 : (wake_r & WAKE_LATCHED_BITS))
                | (reg_wdata & ~WAKE_LATCHED_BITS & ~(8'h01 << WAKE_CLEAR_BIT));
    end
  end

  // miscellaneous detect control, latched bits gated the same way
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      misc_r <= MISC_RST;
    end else if (reg_wr_en && (reg_addr == ADDR_MISC_DET)) begin
      misc_r <= (standby_latch_enable ? (reg_wdata & MISC_LATCHED_BITS)
                 : (misc_r & MISC_LATCHED_BITS))
                | (reg_wdata & ~MISC_LATCHED_BITS);
    end
  end

  // read data selection
  // unmapped addresses read as zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (sticky_rd_one) begin
      rdata_nxt = sticky_one_r;
    end else if (sticky_rd_two) begin
      rdata_nxt = sticky_two_r;
    end else if (st_hit[4]) begin
      rdata_nxt = stat_r[st_hit[3:0]];
    end else if (mk_hit[4]) begin
      rdata_nxt = mask_r[mk_hit[3:0]];
    end else if (reg_addr == ADDR_WAKE_CTRL) begin
      rdata_nxt = wake_r;
    end else if (reg_addr == ADDR_MISC_DET) begin
      rdata_nxt = misc_r;
    end
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      reg_rdata <= reg_rd_en ? rdata_nxt : reg_rdata;
    end
  end

  // unmasked pending flags drive the interrupt
  // every implemented status bit has a mask bit, so each source can be silenced
  always_comb begin
    irq_nxt = 1'b0;
    for (int i = 0; i < N_SRC; i++) begin
      irq_nxt = irq_nxt | (|(stat_r[i] & ~mask_r[i]));
    end
  end

  // control outputs
  assign event_irq = irq_nxt;
  assign wake_ctrl_out = wake_r;
  assign misc_detect_ctrl_out = misc_r;

  // checks
  property p_supply_trip;
    @(posedge sys_clk) disable iff (!resetn)
      sup_q2_r |=> stat_r[IDX_SUPPLY][SUPPLY_TRIP_BIT];
  endproperty
  a_supply_trip: assert property (p_supply_trip)
    else $error("supply trip flag not set");

  property p_masked_quiet;
    @(posedge sys_clk) disable iff (!resetn)
      ((stat_r[IDX_SUPPLY] & ~mask_r[IDX_SUPPLY]) == 8'h00 && (stat_r[IDX_PLL] & ~mask_r[IDX_PLL]) == 8'h00
       && stat_r[IDX_SUPPLY] != 8'h00 && (stat_r[IDX_ADC_OVF] | stat_r[IDX_MIXER]
       | stat_r[IDX_RATE_CONV] | stat_r[IDX_PORT_RX] | stat_r[IDX_PORT_TX] | stat_r[IDX_CODEC]
       | stat_r[IDX_DET_ONE] | stat_r[IDX_DET_TWO] | stat_r[IDX_PART_LOCK] | stat_r[IDX_PLUG]) == 8'h00)
      |-> !event_irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("masked flag raised interrupt");

  property p_irq_unmasked;
    @(posedge sys_clk) disable iff (!resetn)
      (|(stat_r[IDX_SUPPLY] & ~mask_r[IDX_SUPPLY])) |-> event_irq;
  endproperty
  a_irq_unmasked: assert property (p_irq_unmasked)
    else $error("unmasked flag without interrupt");

  property p_reset_masks;
    @(posedge sys_clk)
      !resetn |=> (mask_r[IDX_SUPPLY] == 8'h01 && mask_r[IDX_PLL] == 8'h01
                   && mask_r[IDX_CODEC] == 8'h03 && mask_r[IDX_PART_LOCK] == 8'h7f);
  endproperty
  a_reset_masks: assert property (p_reset_masks)
    else $error("mask reset value wrong");

  property p_unmask_supply;
    @(posedge sys_clk) disable iff (!resetn)
      reg_wr_en && reg_addr == MASK_ADDR[IDX_SUPPLY] && !reg_wdata[SUPPLY_TRIP_BIT]
      |=> !mask_r[IDX_SUPPLY][SUPPLY_TRIP_BIT];
  endproperty
  a_unmask_supply: assert property (p_unmask_supply)
    else $error("supply mask not cleared");

  property p_tip_gate;
    @(posedge sys_clk) disable iff (!resetn)
      !tip_sense_powered |=> (stat_r[IDX_DET_ONE] & TIP_SENSE_BITS) == 8'h00;
  endproperty
  a_tip_gate: assert property (p_tip_gate)
    else $error("tip flag active while unpowered");

  property p_short_gate;
    @(posedge sys_clk) disable iff (!resetn)
      !short_detect_enabled |=> (stat_r[IDX_DET_TWO] & SHORT_DET_BITS) == 8'h00;
  endproperty
  a_short_gate: assert property (p_short_gate)
    else $error("short flag active while disabled");

  property p_restart_clears;
    @(posedge sys_clk) disable iff (!resetn)
      detect_mode_active && !$past(detect_mode_active) && evt_detect_one == 8'h00
      && evt_detect_two == 8'h00 |=> sticky_one_r == 8'h00 && sticky_two_r == 8'h00;
  endproperty
  a_restart_clears: assert property (p_restart_clears)
    else $error("sticky flags survived mode restart");

  property p_latch_gate;
    @(posedge sys_clk) disable iff (!resetn)
      reg_wr_en && reg_addr == ADDR_WAKE_CTRL && !standby_latch_enable
      |=> (wake_r & WAKE_LATCHED_BITS) == ($past(wake_r) & WAKE_LATCHED_BITS);
  endproperty
  a_latch_gate: assert property (p_latch_gate)
    else $error("latched wake bit changed");

  property p_flag_holds;
    @(posedge sys_clk) disable iff (!resetn)
      stat_r[IDX_PLUG] != 8'h00 && !(reg_rd_en && reg_addr == STAT_ADDR[IDX_PLUG])
      |=> (stat_r[IDX_PLUG] & $past(stat_r[IDX_PLUG])) == $past(stat_r[IDX_PLUG]);
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("status flag dropped without read");

  property p_read_clears;
    @(posedge sys_clk) disable iff (!resetn)
      reg_rd_en && reg_addr == STAT_ADDR[IDX_PLUG] && evt_plug == 8'h00
      |=> stat_r[IDX_PLUG] == 8'h00 && reg_rd_valid;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear");

  property p_sticky_view;
    @(posedge sys_clk) disable iff (!resetn)
      sticky_rd_one |=> reg_rd_valid && reg_rdata == $past(sticky_one_r);
  endproperty
  a_sticky_view: assert property (p_sticky_view)
    else $error("sticky view read wrong");

  // scenario coverage
  c_irq_rise: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(event_irq));
  c_wake_clear: cover property (@(posedge sys_clk) disable iff (!resetn)
                                wake_clear ##1 sticky_one_r == 8'h00);
  c_set_on_read: cover property (@(posedge sys_clk) disable iff (!resetn)
                                 stat_rd && evt[st_hit[3:0]] != 8'h00);
  c_sticky_read: cover property (@(posedge sys_clk) disable iff (!resetn) sticky_rd_two);
  c_mode_restart: cover property (@(posedge sys_clk) disable iff (!resetn)
                                  mode_restart ##1 sticky_one_r == 8'h00);

endmodule

`default_nettype wire

/* File: dv/cesm_testbench.sv */
// self-checking bench for the codec event status and mask unit
// assumes cesm_pkg compiled first; drives the register port and events at the falling edge
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import cesm_pkg::*;

  // expected mask values after reset, by index
  localparam logic [7:0] EXP_MRST [N_SRC] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03,
    8'hff, 8'hff, 8'h7f, 8'h01, 8'h01, 8'hff};
  // partial lock mask positions: dac unlock, adc unlock, dac lock, adc lock
  localparam int LOCK_BITS [4] = '{6, 5, 3, 0};

  // clock, reset and register port
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rd_valid;
  // event sources and detect conditions
  logic [7:0] ev [N_SRC] = '{default: 8'h00};
  logic supply_below_threshold = 1'b0;
  logic tip_sense_powered = 1'b1;
  logic short_detect_enabled = 1'b1;
  logic detect_mode_active = 1'b1;
  logic standby_latch_enable = 1'b0;
  // outputs
  logic event_irq;
  logic [7:0] wake_ctrl_out;
  logic [7:0] misc_detect_ctrl_out;
  // bookkeeping
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] v;

  // unit under test
  cesm_event_unit dut (
    .sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .evt_adc_overflow(ev[0]), .evt_mixer(ev[1]), .evt_rate_conv(ev[2]),
    .evt_port_receive(ev[3]), .evt_port_transmit(ev[4]), .evt_codec(ev[5]),
    .evt_detect_one(ev[6]), .evt_detect_two(ev[7]), .evt_partial_lock(ev[8]),
    .evt_pll_lock(ev[10]), .evt_plug(ev[11]),
    .supply_below_threshold(supply_below_threshold),
    .tip_sense_powered(tip_sense_powered), .short_detect_enabled(short_detect_enabled),
    .detect_mode_active(detect_mode_active), .standby_latch_enable(standby_latch_enable),
    .event_irq(event_irq), .wake_ctrl_out(wake_ctrl_out),
    .misc_detect_ctrl_out(misc_detect_ctrl_out)
  );

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  // verdict and end of run
  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // compare one byte
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one write strobe, effective at the edge it is taken
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask

  // one read strobe; answer sampled while rd_valid stands
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    check({7'h00, reg_rd_valid}, 8'h01);
    check(reg_rdata, exp);
  endtask

  // single-cycle event pulse on one source
  task automatic pulse(input int i, input logic [7:0] d);
    @(negedge sys_clk);
    ev[i] = d;
    @(negedge sys_clk);
    ev[i] = 8'h00;
  endtask

  // interrupt level compare
  task automatic irq_is(input logic exp);
    check({7'h00, event_irq}, {7'h00, exp});
  endtask

  // main sequence
  initial begin
    repeat (12) @(negedge sys_clk);
    resetn = 1'b1;
    // reset values of masks and status
    for (int i = 0; i < N_SRC; i++) begin
      rd_chk(MASK_ADDR[i], EXP_MRST[i]);
      rd_chk(STAT_ADDR[i], 8'h00);
    end
    irq_is(1'b0);
    check(wake_ctrl_out, 8'h00);
    rd_chk(16'h1300, 8'h00);
    // every pulsed source: masked, unmasked, read clears
    for (int i = 0; i < N_SRC; i++) begin
      if (i != IDX_SUPPLY) begin
        v = 8'ha5 & STAT_VALID[i];
        pulse(i, v);
        irq_is(1'b0);
        wr(MASK_ADDR[i], 8'h00);
        irq_is(1'b1);
        rd_chk(STAT_ADDR[i], v);
        irq_is(1'b0);
        rd_chk(STAT_ADDR[i], 8'h00);
        wr(MASK_ADDR[i], 8'hff);
      end
    end
    // partial lock mask bits each gate only their own source
    foreach (LOCK_BITS[k]) begin
      v = 8'h01 << LOCK_BITS[k];
      wr(MASK_ADDR[IDX_PART_LOCK], 8'h7f ^ v);
      pulse(IDX_PART_LOCK, 8'h7f ^ v);
      irq_is(1'b0);
      pulse(IDX_PART_LOCK, v);
      irq_is(1'b1);
      rd_chk(STAT_ADDR[IDX_PART_LOCK], 8'h7f);
    end
    wr(MASK_ADDR[IDX_PART_LOCK], 8'h7f);
    // supply trip holds after the supply recovers; mask resets masked
    @(negedge sys_clk);
    supply_below_threshold = 1'b1;
    repeat (5) @(negedge sys_clk);
    supply_below_threshold = 1'b0;
    repeat (4) @(negedge sys_clk);
    irq_is(1'b0);
    wr(16'h131e, 8'h00);
    irq_is(1'b1);
    rd_chk(16'h130d, 8'h01);
    rd_chk(16'h130d, 8'h00);
    wr(16'h131e, 8'h01);
    // empty the sticky flags left by the sweep above
    wr(ADDR_WAKE_CTRL, 8'h01);
    // gated detect flags, normal view
    tip_sense_powered = 1'b0;
    short_detect_enabled = 1'b0;
    pulse(IDX_DET_ONE, 8'hc0);
    pulse(IDX_DET_TWO, 8'h03);
    rd_chk(16'h1309, 8'h00);
    rd_chk(16'h130a, 8'h00);
    // sticky view shows what the gated flags missed
    wr(ADDR_WAKE_CTRL, 8'h02);
    rd_chk(16'h1309, 8'hc0);
    rd_chk(16'h130a, 8'h03);
    // wake clear empties the sticky flags
    pulse(IDX_DET_ONE, 8'hc0);
    wr(ADDR_WAKE_CTRL, 8'h03);
    rd_chk(16'h1309, 8'h00);
    // detect mode off then on also empties them
    pulse(IDX_DET_ONE, 8'hc0);
    detect_mode_active = 1'b0;
    @(negedge sys_clk);
    detect_mode_active = 1'b1;
    @(negedge sys_clk);
    rd_chk(16'h1309, 8'h00);
    // latched control bits change only under standby latch enable
    wr(ADDR_WAKE_CTRL, 8'hfe);
    check(wake_ctrl_out, 8'h02);
    wr(ADDR_MISC_DET, 8'hff);
    check(misc_detect_ctrl_out, 8'h00);
    standby_latch_enable = 1'b1;
    wr(ADDR_WAKE_CTRL, 8'hfe);
    check(wake_ctrl_out, 8'hfe);
    wr(ADDR_MISC_DET, 8'h5a);
    check(misc_detect_ctrl_out, 8'h5a);
    standby_latch_enable = 1'b0;
    wr(ADDR_WAKE_CTRL, 8'h00);
    check(wake_ctrl_out, 8'hfc);
    // restored normal flags after the sticky tests
    tip_sense_powered = 1'b1;
    pulse(IDX_DET_ONE, 8'hc0);
    rd_chk(16'h1309, 8'hc0);
    finish_test();
  end

endmodule

`default_nettype wire
